// *** src/pag_addr_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module pag_addr_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [15:0] mem_addr,
  output logic mem_addr_load,
  output logic mem_addr_fetch
);

  typedef struct packed {
    logic [3:0][15:0] ptr;
    logic [7:0] ext;
    logic [15:0] oaddr;
    logic oload;
    logic ofetch;
    logic [15:0] stat;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pag_state_t;

  pag_state_t s_q;
  pag_state_t s_d;

  logic wr_go;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic is_fetch;
  logic is_exec;
  logic wr_ptr_any;
  logic [7:0] ex_op;
  logic [7:0] ex_disp;
  pag_pkg::pag_cls_t ex_cls;
  pag_pkg::pag_mode_t ex_mode;
  logic [1:0] ex_sel;
  logic ex_two;
  logic ex_legal;
  logic [7:0] disp_eff;
  logic [15:0] base;
  logic [15:0] ea_sum;
  logic [15:0] inc_sum;
  logic [15:0] pages;
  logic [31:0] rd_mux;
  logic rd_ok;

  // Untouched protection bits; every access treated alike
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? nw[15:8] : old[15:8],
               strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_have && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign mem_addr = s_q.oaddr;
  assign mem_addr_load = s_q.oload;
  assign mem_addr_fetch = s_q.ofetch;

  assign wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign wr_addr = {s_q.awaddr[7:2], 2'b00};
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};
  assign is_fetch = wr_go && (wr_addr == pag_pkg::PAG_OFF_FETCH);
  assign is_exec = wr_go && (wr_addr == pag_pkg::PAG_OFF_EXEC);
  assign wr_ptr_any = wr_go && (wr_addr <= pag_pkg::PAG_OFF_PTR3);
  assign pages = {s_q.ptr[3][15:12], s_q.ptr[2][15:12],
                  s_q.ptr[1][15:12], s_q.ptr[0][15:12]};

  assign ex_op = s_q.wdata[pag_pkg::PAG_EXEC_OP_LSB +: 8];
  assign ex_disp = s_q.wdata[pag_pkg::PAG_EXEC_DISP_LSB +: 8];
  assign ex_cls = pag_pkg::pag_cls_t'(
                    s_q.wdata[pag_pkg::PAG_EXEC_CLS_LSB +: 2]);
  assign ex_sel = ex_op[pag_pkg::PAG_OP_PTR_LSB +: 2];
  assign ex_two = ex_op[pag_pkg::PAG_OP_LEN_BIT];
  assign ex_mode = pag_pkg::pag_mode_t'(
                     {ex_op[pag_pkg::PAG_OP_M_BIT], ex_sel != 2'b00});

  always_comb begin
    case (ex_cls)
      pag_pkg::PAG_CLS_LDST: ex_legal = ex_mode != pag_pkg::PAG_MODE_IMMED;
      pag_pkg::PAG_CLS_INCDEC,
      pag_pkg::PAG_CLS_XFER: ex_legal = !ex_op[pag_pkg::PAG_OP_M_BIT];
      pag_pkg::PAG_CLS_IMMG: ex_legal = ex_mode == pag_pkg::PAG_MODE_IMMED;
      default: ex_legal = 1'b0;
    endcase
  end

  assign disp_eff = (ex_disp == pag_pkg::PAG_DISP_SUBST) ? s_q.ext
                                                          : ex_disp;
  assign base = s_q.ptr[ex_sel];

  pag_page_add u_ea_add (
    .base(base),
    .disp(disp_eff),
    .sum(ea_sum)
  );

  pag_page_add u_inc_add (
    .base(s_q.ptr[0]),
    .disp(pag_pkg::PAG_INC_ONE),
    .sum(inc_sum)
  );

  always_comb begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (rd_addr)
      pag_pkg::PAG_OFF_IP: rd_mux = {16'h0000, s_q.ptr[0]};
      pag_pkg::PAG_OFF_PTR1: rd_mux = {16'h0000, s_q.ptr[1]};
      pag_pkg::PAG_OFF_PTR2: rd_mux = {16'h0000, s_q.ptr[2]};
      pag_pkg::PAG_OFF_PTR3: rd_mux = {16'h0000, s_q.ptr[3]};
      pag_pkg::PAG_OFF_EXT: rd_mux = {24'h00_0000, s_q.ext};
      pag_pkg::PAG_OFF_FETCH,
      pag_pkg::PAG_OFF_EXEC: rd_mux = 32'h0000_0000;
      pag_pkg::PAG_OFF_STATUS: rd_mux = {16'h0000, s_q.stat};
      pag_pkg::PAG_OFF_OADDR: rd_mux = {16'h0000, s_q.oaddr};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.oload = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_mux;
      s_d.rresp = rd_ok ? pag_pkg::PAG_RESP_OKAY
                        : pag_pkg::PAG_RESP_SLVERR;
    end
    if (wr_go) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = pag_pkg::PAG_RESP_OKAY;
      case (wr_addr)
        // Pointer register write, merged by byte strobes, only path to page bits
        pag_pkg::PAG_OFF_IP,
        pag_pkg::PAG_OFF_PTR1,
        pag_pkg::PAG_OFF_PTR2,
        pag_pkg::PAG_OFF_PTR3: begin
          s_d.ptr[wr_addr[3:2]] = merge16(s_q.ptr[wr_addr[3:2]],
                                          s_q.wdata[15:0],
                                          s_q.wstrb[1:0]);
        end
        pag_pkg::PAG_OFF_EXT: begin
          if (s_q.wstrb[0]) begin
            s_d.ext = s_q.wdata[7:0];
          end
        end
        pag_pkg::PAG_OFF_FETCH: begin
          s_d.ptr[0] = inc_sum;
          s_d.oaddr = inc_sum;
          s_d.oload = 1'b1;
          s_d.ofetch = 1'b1;
          s_d.stat = 16'h0000;
          s_d.stat[pag_pkg::PAG_ST_FETCH] = 1'b1;
        end
        pag_pkg::PAG_OFF_EXEC: begin
          s_d.stat = 16'h0000;
          s_d.stat[pag_pkg::PAG_ST_TWO] = ex_two;
          if (ex_two && !ex_legal) begin
            s_d.stat[pag_pkg::PAG_ST_ILLEGAL] = 1'b1;
          end else if (ex_two) begin
            case (ex_mode)
              pag_pkg::PAG_MODE_IMMED: begin
                s_d.stat[pag_pkg::PAG_ST_IMM] = 1'b1;
                s_d.stat[pag_pkg::PAG_ST_IMM_LSB +: 8] = ex_disp;
              end
              pag_pkg::PAG_MODE_AUTO: begin
                s_d.ptr[ex_sel] = ea_sum;
                s_d.oaddr = disp_eff[7] ? ea_sum : base;
                s_d.oload = 1'b1;
                s_d.ofetch = 1'b0;
                s_d.stat[pag_pkg::PAG_ST_LOADED] = 1'b1;
              end
              default: begin
                s_d.oaddr = ea_sum;
                s_d.oload = 1'b1;
                s_d.ofetch = 1'b0;
                s_d.stat[pag_pkg::PAG_ST_LOADED] = 1'b1;
              end
            endcase
          end
        end
        pag_pkg::PAG_OFF_STATUS,
        pag_pkg::PAG_OFF_OADDR: s_d.bresp = pag_pkg::PAG_RESP_OKAY;
        default: s_d.bresp = pag_pkg::PAG_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ptr <= {4{pag_pkg::PAG_PTR_RST}};
      s_q.ext <= pag_pkg::PAG_EXT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_fetch_advance;
    is_fetch |=> mem_addr_load && mem_addr_fetch &&
                 mem_addr == s_q.ptr[0] && s_q.ptr[0] == $past(inc_sum);
  endproperty
  a_fetch_advance: assert property (p_fetch_advance)
    else $error("fetch did not advance pointer first");

  property p_fetch_wrap;
    is_fetch && s_q.ptr[0][11:0] == 12'hfff |=>
      s_q.ptr[0][11:0] == 12'h000 && $stable(pages);
  endproperty
  a_fetch_wrap: assert property (p_fetch_wrap)
    else $error("fetch did not wrap inside page");

  property p_page_keep;
    !wr_ptr_any |=> $stable(pages);
  endproperty
  a_page_keep: assert property (p_page_keep)
    else $error("page bits changed without a load");

  property p_one_byte;
    is_exec && !ex_two |=> !mem_addr_load ##1 !mem_addr_load;
  endproperty
  a_one_byte: assert property (p_one_byte)
    else $error("one-byte opcode produced an address");

  property p_index_keep;
    is_exec && ex_two && ex_legal && ex_mode == pag_pkg::PAG_MODE_INDEX
      |=> $stable(s_q.ptr) && mem_addr_load && mem_addr == $past(ea_sum);
  endproperty
  a_index_keep: assert property (p_index_keep)
    else $error("indexed access wrong or pointer moved");

  property p_auto_adjust;
    is_exec && ex_two && ex_legal && ex_mode == pag_pkg::PAG_MODE_AUTO
      |=> s_q.ptr[$past(ex_sel)] == $past(ea_sum) &&
          mem_addr == ($past(disp_eff[7]) ? $past(ea_sum) : $past(base));
  endproperty
  a_auto_adjust: assert property (p_auto_adjust)
    else $error("auto-index address or update wrong");

  property p_ext_subst;
    is_exec && ex_two && ex_legal && ex_disp == pag_pkg::PAG_DISP_SUBST &&
      ex_mode == pag_pkg::PAG_MODE_PCREL
      |=> mem_addr[11:0] == $past(s_q.ptr[0][11:0]) +
                            {{4{$past(s_q.ext[7])}}, $past(s_q.ext)};
  endproperty
  a_ext_subst: assert property (p_ext_subst)
    else $error("extension not substituted for -128");

  property p_immediate;
    is_exec && ex_two && ex_legal && ex_mode == pag_pkg::PAG_MODE_IMMED
      |=> !mem_addr_load && s_q.stat[15:8] == $past(ex_disp);
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate mode made a memory access");

  property p_illegal;
    is_exec && ex_two && ex_op[pag_pkg::PAG_OP_M_BIT] &&
      (ex_cls == pag_pkg::PAG_CLS_INCDEC || ex_cls == pag_pkg::PAG_CLS_XFER)
      |=> !mem_addr_load && s_q.stat[pag_pkg::PAG_ST_ILLEGAL];
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("disallowed mode was accepted");

  property p_page_of_ea;
    mem_addr_load && !mem_addr_fetch |->
      mem_addr[15:12] == $past(base[15:12]);
  endproperty
  a_page_of_ea: assert property (p_page_of_ea)
    else $error("effective address left base page");

  c_fetch_wrap: cover property (is_fetch && s_q.ptr[0][11:0] == 12'hfff);
  c_auto_neg: cover property (is_exec && ex_legal && disp_eff[7] &&
                              ex_mode == pag_pkg::PAG_MODE_AUTO);
  c_ext_use: cover property (is_exec && ex_legal &&
                             ex_disp == pag_pkg::PAG_DISP_SUBST);
  c_imm: cover property (is_exec && ex_legal &&
                         ex_mode == pag_pkg::PAG_MODE_IMMED);

endmodule
`default_nettype wire

// *** include/pag_pkg.sv ***
package pag_pkg;

  // Byte addresses of the software-visible registers
  localparam logic [7:0] PAG_OFF_IP = 8'h00;
  localparam logic [7:0] PAG_OFF_PTR1 = 8'h04;
  localparam logic [7:0] PAG_OFF_PTR2 = 8'h08;
  localparam logic [7:0] PAG_OFF_PTR3 = 8'h0c;
  localparam logic [7:0] PAG_OFF_EXT = 8'h10;
  localparam logic [7:0] PAG_OFF_FETCH = 8'h14;
  localparam logic [7:0] PAG_OFF_EXEC = 8'h18;
  localparam logic [7:0] PAG_OFF_STATUS = 8'h1c;
  localparam logic [7:0] PAG_OFF_OADDR = 8'h20;

  // Execute command word layout
  localparam int PAG_EXEC_OP_LSB = 0;
  localparam int PAG_EXEC_DISP_LSB = 8;
  localparam int PAG_EXEC_CLS_LSB = 16;

  // Opcode byte fields
  localparam int PAG_OP_LEN_BIT = 7;
  localparam int PAG_OP_M_BIT = 2;
  localparam int PAG_OP_PTR_LSB = 0;

  // Status register bits
  localparam int PAG_ST_LOADED = 0;
  localparam int PAG_ST_IMM = 1;
  localparam int PAG_ST_ILLEGAL = 2;
  localparam int PAG_ST_TWO = 3;
  localparam int PAG_ST_FETCH = 4;
  localparam int PAG_ST_IMM_LSB = 8;

  // Address layout: page above in-page offset
  localparam int PAG_PAGE_LSB = 12;
  localparam logic [7:0] PAG_DISP_SUBST = 8'h80;
  localparam logic [7:0] PAG_INC_ONE = 8'h01;

  // Reset values
  localparam logic [15:0] PAG_PTR_RST = 16'h0000;
  localparam logic [7:0] PAG_EXT_RST = 8'h00;

  localparam logic [1:0] PAG_RESP_OKAY = 2'b00;
  localparam logic [1:0] PAG_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    PAG_CLS_LDST = 2'b00,
    PAG_CLS_INCDEC = 2'b01,
    PAG_CLS_XFER = 2'b10,
    PAG_CLS_IMMG = 2'b11
  } pag_cls_t;

  typedef enum logic [1:0] {
    PAG_MODE_PCREL = 2'b00,
    PAG_MODE_INDEX = 2'b01,
    PAG_MODE_IMMED = 2'b10,
    PAG_MODE_AUTO = 2'b11
  } pag_mode_t;

endpackage

// *** src/pag_page_add.sv ***
`timescale 1ns/1ps
`default_nettype none
module pag_page_add (
  input wire logic [15:0] base,
  input wire logic [7:0] disp,
  output logic [15:0] sum
);
  logic [11:0] disp_ext;
  logic [11:0] low_sum;

  assign disp_ext = {{4{disp[7]}}, disp};
  // Carry out of bit 11 dropped
  assign low_sum = base[11:0] + disp_ext;
  assign sum = {base[15:pag_pkg::PAG_PAGE_LSB], low_sum};
endmodule
`default_nettype wire

// *** tb/pag_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pag_mem_model #(
  parameter logic [3:0] PERIPH_PAGE = 4'hf
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] mem_addr,
  input wire logic mem_addr_load,
  input wire logic mem_addr_fetch,
  output logic [15:0] n_access,
  output logic [15:0] n_periph
);
  typedef struct packed {
    logic [15:0] acc;
    logic [15:0] per;
  } pag_mm_st_t;
  pag_mm_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (mem_addr_load) begin
      st_d.acc = st_q.acc + 16'h1;
      // Same decode as memory; a data load in page PERIPH_PAGE picks the device, a fetch never does
      if (!mem_addr_fetch && mem_addr[15:12] == PERIPH_PAGE) begin
        st_d.per = st_q.per + 16'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign n_access = st_q.acc;
  assign n_periph = st_q.per;
endmodule
`default_nettype wire

// *** tb/paged_address_generator_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module paged_address_generator_test;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0] r;
  } pag_rd_t;
  localparam logic [31:0] FULL = 32'hffffffff;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, mem_addr_load;
  logic mem_addr_fetch;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] mem_addr, n_access, n_periph, ip, b;
  pag_rd_t rd_q[$];
  pag_rd_t e;
  logic [1:0] b_q[$];
  logic [16:0] a_q[$];
  int n_errors, cmp_count, n_load, n_per;

  pag_addr_gen i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mem_addr(mem_addr),
    .mem_addr_load(mem_addr_load), .mem_addr_fetch(mem_addr_fetch));
  pag_mem_model i_mem (.aclk(aclk), .aresetn(aresetn), .mem_addr(mem_addr),
    .mem_addr_load(mem_addr_load), .mem_addr_fetch(mem_addr_fetch),
    .n_access(n_access), .n_periph(n_periph));

  initial begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end

  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'h1) begin
      n_errors++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  function automatic logic [15:0] pa(input logic [15:0] bs,
                                     input logic [7:0] dd);
    pa = {bs[15:12], bs[11:0] + {{4{dd[7]}}, dd}};
  endfunction

  // Results pop in arrival order; the bus allows one of each in flight
  always @(posedge aclk) begin
    if (aresetn === 1'h1) begin
      if (bvalid && bready) begin
        chk(b_q.size() != 0 && bresp === b_q.pop_front(), "wr resp");
      end
      if (rvalid && rready) begin
        e = rd_q.size() != 0 ? rd_q.pop_front() : '1;
        chk((rdata & e.m) === (e.d & e.m) && rresp === e.r, "rd");
      end
      if (mem_addr_load === 1'h1) begin
        chk(a_q.size() != 0 &&
            {mem_addr_fetch, mem_addr} === a_q.pop_front(), "address load");
      end
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic er);
    b_q.push_back(er ? pag_pkg::PAG_RESP_SLVERR : pag_pkg::PAG_RESP_OKAY);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m, input logic er);
    rd_q.push_back({v, m, er ? pag_pkg::PAG_RESP_SLVERR : 2'h0});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
  endtask

  task automatic fetch();
    ip = pa(ip, 8'h01);
    a_q.push_back({1'h1, ip});
    n_load++;
    wr(pag_pkg::PAG_OFF_FETCH, 32'h0, 1'h0);
  endtask

  task automatic exec(input logic [7:0] op, input logic [7:0] dp,
                      input logic [1:0] cl, input logic ld,
                      input logic [15:0] ea);
    if (ld) begin
      a_q.push_back({1'h0, ea});
      n_load++;
      if (ea[15:12] == 4'hf) n_per++;
    end
    wr(pag_pkg::PAG_OFF_EXEC, {14'h0, cl, dp, op}, 1'h0);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
    void'($urandom(32'h5340c90c));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, FULL, 1'h0);
    rd(8'h24, 32'h0, FULL, 1'h1);
    wr(8'h24, 32'h1234, 1'h1);
    ip = 16'h1ffe;
    wr(pag_pkg::PAG_OFF_IP, {16'h0, ip}, 1'h0);
    fetch();
    fetch();
    rd(pag_pkg::PAG_OFF_IP, 32'h1000, FULL, 1'h0);
    exec(8'h80, 8'h05, pag_pkg::PAG_CLS_LDST, 1'h1, 16'h1005);
    ip = 16'h0fb3;
    wr(pag_pkg::PAG_OFF_IP, {16'h0, ip}, 1'h0);
    fetch();
    exec(8'h80, 8'h4d, pag_pkg::PAG_CLS_XFER, 1'h1, 16'h0001);
    // Indexed on pointers 1 to 3, one instruction class apiece
    for (int k = 1; k < 4; k++) begin
      b = 16'($urandom);
      d = 8'($urandom);
      if (d == 8'h80) d = 8'h7f;
      wr(8'(4 * k), {16'h0, b}, 1'h0);
      exec(8'h80 | 8'(k), d, 2'(k - 1), 1'h1, pa(b, d));
      rd(8'(4 * k), {16'h0, b}, FULL, 1'h0);
    end
    wr(pag_pkg::PAG_OFF_EXT, 32'hf0, 1'h0);
    wr(pag_pkg::PAG_OFF_PTR1, 32'hf010, 1'h0);
    exec(8'h81, 8'h80, pag_pkg::PAG_CLS_LDST, 1'h1, 16'hf000);
    exec(8'h80, 8'h80, pag_pkg::PAG_CLS_LDST, 1'h1, 16'h0fa4);
    wr(pag_pkg::PAG_OFF_PTR2, 32'h3ffe, 1'h0);
    exec(8'h86, 8'h05, pag_pkg::PAG_CLS_LDST, 1'h1, 16'h3ffe);
    rd(pag_pkg::PAG_OFF_PTR2, 32'h3003, FULL, 1'h0);
    wr(pag_pkg::PAG_OFF_PTR3, 32'h5001, 1'h0);
    exec(8'h87, 8'hfe, pag_pkg::PAG_CLS_LDST, 1'h1, 16'h5fff);
    rd(pag_pkg::PAG_OFF_PTR3, 32'h5fff, FULL, 1'h0);
    exec(8'h84, 8'h5a, pag_pkg::PAG_CLS_IMMG, 1'h0, 16'h0);
    rd(pag_pkg::PAG_OFF_STATUS, 32'h5a0a, 32'hff0f, 1'h0);
    // Auto mode in the inc/dec and transfer classes goes nowhere
    for (int k = 1; k < 3; k++) begin
      exec(8'h85, 8'h01, 2'(k), 1'h0, 16'h0);
      rd(pag_pkg::PAG_OFF_STATUS, 32'h0c, 32'h0f, 1'h0);
    end
    rd(pag_pkg::PAG_OFF_PTR1, 32'hf010, FULL, 1'h0);
    exec(8'h01, 8'h10, pag_pkg::PAG_CLS_LDST, 1'h0, 16'h0);
    rd(pag_pkg::PAG_OFF_STATUS, 32'h0, 32'h09, 1'h0);
    rd(pag_pkg::PAG_OFF_OADDR, 32'h5fff, FULL, 1'h0);
    repeat (4) @(posedge aclk);
    chk(a_q.size() == 0, "address loads missing");
    chk(n_access === 16'(n_load) && n_periph === 16'(n_per), "bus count");
    give_verdict();
  end
endmodule
`default_nettype wire
